// [verilog/swk_cfg.svh]
// constants of the wake-frame configuration block: offsets, fields, resets, timing
// assumes a 7-bit register address space reached by 16-bit serial frames
`ifndef SWK_CFG_SVH
`define SWK_CFG_SVH

`define ADDR_BITS        7
`define FRAME_BITS       16
`define MODE_BIT         7

`define OFS_PAYLOAD_ONE  7'h32
`define OFS_PAYLOAD_ZERO 7'h33
`define OFS_FD_CFG       7'h34
`define OFS_FINE_TRIM    7'h38
`define OFS_OPTIONS      7'h39
`define OFS_CAL_HIGH     7'h3A
`define OFS_CAL_LOW      7'h3B
`define OFS_REC_ONE      7'h3C
`define OFS_REC_TWO      7'h3D

`define RST_PAYLOAD      8'h00
`define RST_FD_CFG       8'h00
`define RST_FINE_TRIM    8'h00
`define RST_OPTIONS      8'h00
`define RST_REC_ONE      8'h04
`define RST_REC_TWO      8'h00

`define MASK_FD_CFG      8'h2F
`define MASK_OPTIONS     8'h9F
`define MASK_REC_ONE     8'h0D
`define MASK_REC_TWO     8'h03
`define MASK_REC_ONE_RS  8'h0F
`define MASK_OPT_RS      8'h9F

`define FD_EN_BIT        0
`define FD_FILT_LSB      1
`define FD_ERRCNT_BIT    5
`define OPT_RXSEL_BIT    7
`define COARSE_MSB       4
`define FINE_MSB         4
`define TEMP_LSB         5
`define REC_EN_BIT       0
`define REC_FILT_LSB     2

`define KEY_OPEN         2'h3

`define CLK_PERIOD_PS    40000
`define DOM_FILT_STEP_NS 50
`define DOM_FILT_LONG_NS 775
`define DOM_FILT_LONG    3'h7

`define TC_SHORT         6'h08
`define TC_MID           6'h10
`define TC_LONG          6'h20
`define SPACE_LONG_MIN   4'h2
`define SPACE_LONG_MAX   4'h3
`define SPACE_MID_MIN    4'h4
`define SPACE_MID_MAX    4'h8
`define SPACE_SHORT_MIN  4'h9
`define SPACE_SHORT_MAX  4'hA

`define REC_CLK_BASE_MHZ 7'h50

`endif

// [verilog/swk_pkg.sv]
// types shared by the wake-frame configuration block
// assumes swk_cfg.svh holds all numeric constants
package swk_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] addr_t;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_HEAD,
        PH_BODY
    } spi_phase_e;
    typedef enum logic [1:0] {
        FC_SHORT,
        FC_MID,
        FC_LONG,
        FC_ADAPT
    } filt_code_e;
endpackage

// [verilog/swk_spi_port.sv]
// serial control port: 16-bit frames, lsb first, sampled in the sys_clk domain
// assumes serial clock idles low and each half period spans at least 4 sys_clk cycles
`timescale 1ns/1ps
`default_nettype none
`include "swk_cfg.svh"

module swk_spi_port (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          csN,
    input  wire logic          sclk,
    input  wire logic          sdi,
    output logic               sdo,
    output logic               sdoEn,
    output swk_pkg::addr_t     addr,
    output logic               rdLoad,
    input  wire swk_pkg::byte_t rdData,
    output logic               wrStrobe,
    output swk_pkg::byte_t     wrData
);
    swk_pkg::spi_phase_e phase_r;
    logic [15:0] frame_r;
    logic [4:0]  bitCnt_r;
    logic        sclkPrev_r;
    logic        csPrev_r;
    logic [7:0]  outShift_r;
    logic        sclkRise;
    logic        sclkFall;
    logic        csEnd;

    assign sclkRise = sclk & ~sclkPrev_r;
    assign sclkFall = ~sclk & sclkPrev_r;
    assign csEnd    = csN & ~csPrev_r;
    assign addr     = frame_r[6:0];
    assign wrData   = frame_r[15:8];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrev_r <= 1'b0;
            csPrev_r   <= 1'b1;
        end else begin
            sclkPrev_r <= sclk;
            csPrev_r   <= csN;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r  <= swk_pkg::PH_IDLE;
            bitCnt_r <= 5'h00;
            frame_r  <= 16'h0000;
            rdLoad   <= 1'b0;
        end else begin
            rdLoad <= 1'b0;
            if (csN) begin
                phase_r  <= swk_pkg::PH_IDLE;
                bitCnt_r <= 5'h00;
            end else begin
                case (phase_r)
                    swk_pkg::PH_IDLE: begin
                        phase_r  <= swk_pkg::PH_HEAD;
                        bitCnt_r <= 5'h00;
                    end
                    swk_pkg::PH_HEAD: begin
                        if (sclkRise) begin
                            frame_r[bitCnt_r[3:0]] <= sdi;
                            bitCnt_r <= bitCnt_r + 5'h01;
                            if (bitCnt_r == 5'h07) begin
                                phase_r <= swk_pkg::PH_BODY;
                                rdLoad  <= 1'b1;
                            end
                        end
                    end
                    swk_pkg::PH_BODY: begin
                        // extra clocks past 16 bits spoil the frame count
                        if (sclkRise && bitCnt_r != 5'h11) begin
                            if (bitCnt_r < 5'h10) begin
                                frame_r[bitCnt_r[3:0]] <= sdi;
                            end
                            bitCnt_r <= bitCnt_r + 5'h01;
                        end
                    end
                    default: phase_r <= swk_pkg::PH_IDLE;
                endcase
            end
        end
    end

    // read byte leaves during the second half of the same frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outShift_r <= 8'h00;
            sdo        <= 1'b0;
            sdoEn      <= 1'b0;
        end else begin
            sdoEn <= ~csN;
            if (csN) begin
                sdo <= 1'b0;
            end else if (rdLoad) begin
                outShift_r <= rdData;
            end else if (sclkFall && phase_r == swk_pkg::PH_BODY) begin
                sdo        <= outShift_r[0];
                outShift_r <= {1'b0, outShift_r[7:1]};
            end
        end
    end

    // only whole 16-bit frames with the mode bit set commit a write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrStrobe <= 1'b0;
        end else begin
            wrStrobe <= csEnd && bitCnt_r == 5'h10 && frame_r[`MODE_BIT];
        end
    end
endmodule // swk_spi_port
`default_nettype wire

// [verilog/swk_config_top.sv]
// wake-frame configuration registers, trimming, dominant filter and recovery setup
// assumes trim key, calibration words, soft reset and restart come from the chip core
// Summary of operation
// - payload byte registers hold full 8 bits
// - error counter stops only with flag and FD
// - dominant filter 50-350 ns steps, code 7 775
// - bit 0 enables FD tolerant mode
// - trim bits written only when key is 11
// - five fine bits give 32 monotonic steps
// - receiver select guarded by key, 1 wake receiver
// - five coarse bits, non-monotonic coarse range
// - calibration registers read only, writes ignored
// - filter code selects time constant 8,16,32
// - code 3 adapts constant to edge spacing
// - recovery enable bit 0, reset value 0x04
// - two-bit recovery input clock select
// - clock codes map to 80,40,20,10 MHz
// - reserved bits read as zero
// - restart clears upper bits, keeps clock select
`timescale 1ns/1ps
`default_nettype none
`include "swk_cfg.svh"

module swk_config_top (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          softReset,
    input  wire logic          restart,
    input  wire logic [1:0]    trimKey,
    input  wire logic [7:0]    calHigh,
    input  wire logic [7:0]    calLow,
    input  wire logic          busDominant,
    input  wire logic          edgeValid,
    input  wire logic [3:0]    edgeSpacing,
    input  wire logic          spiCsN,
    input  wire logic          spiClk,
    input  wire logic          spiDataIn,
    output logic               spiDataOut,
    output logic               spiDataOutEn,
    output logic [7:0]         payloadByteZero,
    output logic [7:0]         payloadByteOne,
    output logic               fdTolerantEnable,
    output logic               errorCounterRun,
    output logic [2:0]         dominantFilterTime,
    output logic               dominantDetected,
    output logic [4:0]         fineTrim,
    output logic [2:0]         tempCoeffTrim,
    output logic [4:0]         coarseTrim,
    output logic               receiverSelect,
    output logic               recoveryEnable,
    output logic [5:0]         filterTimeConstant,
    output logic [1:0]         oscClockSelect,
    output logic [6:0]         recoveryClockMhz
);
    swk_pkg::addr_t regAddr;
    swk_pkg::byte_t wrData;
    swk_pkg::byte_t rdData;
    logic           rdLoad;
    logic           wrStrobe;
    logic           keyOpen;

    swk_pkg::byte_t payloadZero_r;
    swk_pkg::byte_t payloadOne_r;
    swk_pkg::byte_t fdCfg_r;
    swk_pkg::byte_t fineTrim_r;
    swk_pkg::byte_t options_r;
    swk_pkg::byte_t calHigh_r;
    swk_pkg::byte_t calLow_r;
    swk_pkg::byte_t recOne_r;
    swk_pkg::byte_t recTwo_r;

    logic [4:0]     domCount_r;
    logic [4:0]     domLimit;
    logic [5:0]     adaptConst_r;
    logic [5:0]     filterTimeConstant_nxt;

    swk_spi_port serialPort (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .csN      (spiCsN),
        .sclk     (spiClk),
        .sdi      (spiDataIn),
        .sdo      (spiDataOut),
        .sdoEn    (spiDataOutEn),
        .addr     (regAddr),
        .rdLoad   (rdLoad),
        .rdData   (rdData),
        .wrStrobe (wrStrobe),
        .wrData   (wrData)
    );

    assign keyOpen = (trimKey == `KEY_OPEN);

    // payload bytes: plain 8-bit storage, kept across a restart
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            payloadZero_r <= `RST_PAYLOAD;
            payloadOne_r  <= `RST_PAYLOAD;
        end else if (softReset) begin
            payloadZero_r <= `RST_PAYLOAD;
            payloadOne_r  <= `RST_PAYLOAD;
        end else if (wrStrobe) begin
            if (regAddr == `OFS_PAYLOAD_ZERO) begin
                payloadZero_r <= wrData;
            end
            if (regAddr == `OFS_PAYLOAD_ONE) begin
                payloadOne_r <= wrData;
            end
        end
    end

    // FD tolerance configuration; reserved positions are never stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fdCfg_r <= `RST_FD_CFG;
        end else if (softReset) begin
            fdCfg_r <= `RST_FD_CFG;
        end else if (wrStrobe && regAddr == `OFS_FD_CFG) begin
            fdCfg_r <= wrData & `MASK_FD_CFG;
        end
    end

    // fine trim: locked writes vanish silently, no error flag exists
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fineTrim_r <= `RST_FINE_TRIM;
        end else if (softReset) begin
            fineTrim_r <= `RST_FINE_TRIM;
        end else if (wrStrobe && regAddr == `OFS_FINE_TRIM && keyOpen) begin
            fineTrim_r <= wrData;
        end
    end

    // options: receiver select plus coarse trim, both behind the key;
    // a full-byte write is the only way in, so software must repeat coarse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            options_r <= `RST_OPTIONS;
        end else if (softReset) begin
            options_r <= `RST_OPTIONS;
        end else if (restart) begin
            options_r <= options_r & `MASK_OPT_RS;
        end else if (wrStrobe && regAddr == `OFS_OPTIONS && keyOpen) begin
            options_r <= wrData & `MASK_OPTIONS;
        end
    end

    // calibration results follow hardware; the bus has no write path here
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            calHigh_r <= 8'h00;
            calLow_r  <= 8'h00;
        end else begin
            calHigh_r <= calHigh;
            calLow_r  <= calLow;
        end
    end

    // recovery control one: enable and filter code
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            recOne_r <= `RST_REC_ONE;
        end else if (softReset) begin
            recOne_r <= `RST_REC_ONE;
        end else if (restart) begin
            recOne_r <= recOne_r & `MASK_REC_ONE_RS;
        end else if (wrStrobe && regAddr == `OFS_REC_ONE) begin
            recOne_r <= wrData & `MASK_REC_ONE;
        end
    end

    // recovery control two: clock select survives a restart
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            recTwo_r <= `RST_REC_TWO;
        end else if (softReset) begin
            recTwo_r <= `RST_REC_TWO;
        end else if (restart) begin
            recTwo_r <= recTwo_r & `MASK_REC_TWO;
        end else if (wrStrobe && regAddr == `OFS_REC_TWO) begin
            recTwo_r <= wrData & `MASK_REC_TWO;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        case (regAddr)
            `OFS_PAYLOAD_ZERO: rdData = payloadZero_r;
            `OFS_PAYLOAD_ONE:  rdData = payloadOne_r;
            `OFS_FD_CFG:       rdData = fdCfg_r;
            `OFS_FINE_TRIM:    rdData = fineTrim_r;
            // receiver select hidden while the key is shut
            `OFS_OPTIONS:      rdData = {options_r[7] & keyOpen, options_r[6:0]};
            `OFS_CAL_HIGH:     rdData = calHigh_r;
            `OFS_CAL_LOW:      rdData = calLow_r;
            `OFS_REC_ONE:      rdData = recOne_r;
            `OFS_REC_TWO:      rdData = recTwo_r;
            default:           rdData = 8'h00;
        endcase
    end

    // least filter time rounded up to whole sys_clk cycles
    function automatic logic [4:0] domCycles(input logic [2:0] code);
        logic [31:0] ns;
        logic [31:0] cyc;
        ns  = (code == `DOM_FILT_LONG) ? `DOM_FILT_LONG_NS
                                       : (32'(code) + 32'd1) * `DOM_FILT_STEP_NS;
        cyc = (ns * 32'd1000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS;
        return cyc[4:0];
    endfunction

    assign domLimit = domCycles(fdCfg_r[`FD_FILT_LSB+2:`FD_FILT_LSB]);

    // dominant filter: a dominant level counts only once it outlasts the
    // selected time; shorter FD-phase glitches are swallowed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            domCount_r       <= 5'h00;
            dominantDetected <= 1'b0;
        end else if (!busDominant || !fdCfg_r[`FD_EN_BIT]) begin
            domCount_r       <= 5'h00;
            dominantDetected <= busDominant;
        end else begin
            if (domCount_r < domLimit) begin
                domCount_r <= domCount_r + 5'h01;
            end
            dominantDetected <= (domCount_r + 5'h01 >= domLimit);
        end
    end

    // adaptive constant tracks the latest valid edge spacing of 2 to 10 bits; other spacings keep it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            adaptConst_r <= `TC_MID;
        end else if (edgeValid) begin
            if (edgeSpacing >= `SPACE_LONG_MIN && edgeSpacing <= `SPACE_LONG_MAX) begin
                adaptConst_r <= `TC_LONG;
            end else if (edgeSpacing >= `SPACE_MID_MIN && edgeSpacing <= `SPACE_MID_MAX) begin
                adaptConst_r <= `TC_MID;
            end else if (edgeSpacing >= `SPACE_SHORT_MIN
                         && edgeSpacing <= `SPACE_SHORT_MAX) begin
                adaptConst_r <= `TC_SHORT;
            end
        end
    end

    always_comb begin
        case (swk_pkg::filt_code_e'(recOne_r[`REC_FILT_LSB+1:`REC_FILT_LSB]))
            swk_pkg::FC_SHORT: filterTimeConstant_nxt = `TC_SHORT;
            swk_pkg::FC_MID:   filterTimeConstant_nxt = `TC_MID;
            swk_pkg::FC_LONG:  filterTimeConstant_nxt = `TC_LONG;
            swk_pkg::FC_ADAPT: filterTimeConstant_nxt = adaptConst_r;
            default:           filterTimeConstant_nxt = `TC_MID;
        endcase
    end

    // all outputs are flopped copies so downstream sees glitch-free levels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            payloadByteZero    <= `RST_PAYLOAD;
            payloadByteOne     <= `RST_PAYLOAD;
            fdTolerantEnable   <= 1'b0;
            errorCounterRun    <= 1'b1;
            dominantFilterTime <= 3'h0;
            fineTrim           <= 5'h00;
            tempCoeffTrim      <= 3'h0;
            coarseTrim         <= 5'h00;
            receiverSelect     <= 1'b0;
            recoveryEnable     <= 1'b0;
            filterTimeConstant <= `TC_MID;
            oscClockSelect     <= 2'h0;
            recoveryClockMhz   <= `REC_CLK_BASE_MHZ;
        end else begin
            payloadByteZero    <= payloadZero_r;
            payloadByteOne     <= payloadOne_r;
            fdTolerantEnable   <= fdCfg_r[`FD_EN_BIT];
            errorCounterRun    <= ~(fdCfg_r[`FD_ERRCNT_BIT] & fdCfg_r[`FD_EN_BIT]);
            dominantFilterTime <= fdCfg_r[`FD_FILT_LSB+2:`FD_FILT_LSB];
            fineTrim           <= fineTrim_r[`FINE_MSB:0];
            tempCoeffTrim      <= fineTrim_r[7:`TEMP_LSB];
            coarseTrim         <= options_r[`COARSE_MSB:0];
            receiverSelect     <= options_r[`OPT_RXSEL_BIT];
            recoveryEnable     <= recOne_r[`REC_EN_BIT];
            filterTimeConstant <= filterTimeConstant_nxt;
            oscClockSelect     <= recTwo_r[1:0];
            recoveryClockMhz   <= `REC_CLK_BASE_MHZ >> recTwo_r[1:0];
        end
    end
endmodule // swk_config_top
`default_nettype wire

// [testbench/can_bus_node.sv]
// behavioural CAN node: drives bus level and falling-edge spacing reports
// assumes the bench calls its tasks just after a rising sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
    input  wire logic       sys_clk,
    output logic            busDominant,
    output logic            edgeValid,
    output logic [3:0]      edgeSpacing
);
    initial begin
        busDominant = 1'b0;
        edgeValid   = 1'b0;
        edgeSpacing = 4'h0;
    end
    task automatic drive(input logic lvl);
        busDominant <= lvl;
    endtask
    // one spacing report, in bits between falling edges
    task automatic gap(input logic [3:0] bits);
        edgeSpacing <= bits;
        edgeValid   <= 1'b1;
        @(posedge sys_clk);
        edgeValid   <= 1'b0;
        // spacing is not held past its strobe
        edgeSpacing <= ~bits;
    endtask
endmodule // can_bus_node
`default_nettype wire

// [testbench/swk_config_top_assertions.sv]
// port assertions for the wake-frame configuration block
// assumes one sys_clk domain; bound to swk_config_top below
`timescale 1ns/1ps
`default_nettype none
module swk_config_top_assertions (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [1:0] trimKey,
    input wire logic       busDominant,
    input wire logic       spiCsN,
    input wire logic       spiDataOut,
    input wire logic       spiDataOutEn,
    input wire logic       fdTolerantEnable,
    input wire logic       errorCounterRun,
    input wire logic [2:0] dominantFilterTime,
    input wire logic       dominantDetected,
    input wire logic [4:0] fineTrim,
    input wire logic [2:0] tempCoeffTrim,
    input wire logic [4:0] coarseTrim,
    input wire logic       receiverSelect,
    input wire logic [5:0] filterTimeConstant,
    input wire logic [1:0] oscClockSelect,
    input wire logic [6:0] recoveryClockMhz
);
    logic [5:0] domRun_r;
    logic [4:0] domNeed;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            domRun_r <= 6'h00;
        end else if (!busDominant) begin
            domRun_r <= 6'h00;
        end else if (domRun_r != 6'h3F) begin
            domRun_r <= domRun_r + 6'h01;
        end
    end
    // filter length in cycles; the longest code is not on the 50 ns grid
    always_comb begin
        if (dominantFilterTime == 3'h7) begin
            domNeed = 5'h14;
        end else begin
            domNeed = {2'h0, dominantFilterTime} + ((dominantFilterTime > 3'h3) ? 5'h03 : 5'h02);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence quietTwo;
        !dominantDetected [*2];
    endsequence
    errRun_a: assert property (!fdTolerantEnable |-> errorCounterRun)
        else $error("error counter stopped with tolerant mode off");
    clkMap_a: assert property (recoveryClockMhz == (7'h50 >> oscClockSelect))
        else $error("recovery clock does not match its select");
    tcLegal_a: assert property (filterTimeConstant inside {6'h08, 6'h10, 6'h20})
        else $error("filter time constant off its set");
    domFollow_a: assert property (!fdTolerantEnable && $past(!fdTolerantEnable)
        |-> dominantDetected == $past(busDominant)) else $error("detector not following bus");
    domMin_a: assert property (fdTolerantEnable && $rose(busDominant) |-> quietTwo)
        else $error("dominant reported too early");
    domEarly_a: assert property ($rose(dominantDetected) && fdTolerantEnable
        |-> domRun_r == {1'b0, domNeed}) else $error("dominant filter too short");
    domLate_a: assert property (fdTolerantEnable && busDominant
        && domRun_r == {1'b0, domNeed} |-> dominantDetected)
        else $error("dominant filter too long");
    outEn_a: assert property (spiDataOutEn == !$past(spiCsN))
        else $error("serial output enable off chip select");
    outIdle_a: assert property (spiCsN && $past(spiCsN) |-> !spiDataOut)
        else $error("serial output not idle");
    trimKey_a: assert property ($changed({fineTrim, tempCoeffTrim, coarseTrim,
        receiverSelect}) |-> trimKey == 2'h3) else $error("trim changed while locked");
endmodule // swk_config_top_assertions
bind swk_config_top swk_config_top_assertions i_swk_config_top_assertions (
    .sys_clk, .rst_n, .trimKey, .busDominant, .spiCsN, .spiDataOut, .spiDataOutEn,
    .fdTolerantEnable, .errorCounterRun, .dominantFilterTime, .dominantDetected,
    .fineTrim, .tempCoeffTrim, .coarseTrim, .receiverSelect, .filterTimeConstant,
    .oscClockSelect, .recoveryClockMhz
);
`default_nettype wire

// [testbench/can_wake_frame_cdr_config_tb_top.sv]
// self-checking bench for the wake-frame configuration block
// assumes 25 MHz sys_clk; frames lsb first, mode bit 1 = write
`timescale 1ns/1ps
`default_nettype none
module can_wake_frame_cdr_config_tb_top;
    logic       sys_clk, rst_n, softReset, restart, busDominant, edgeValid;
    logic       spiCsN, spiClk, spiDataIn, spiDataOut, spiDataOutEn;
    logic       fdTolerantEnable, errorCounterRun, dominantDetected;
    logic       receiverSelect, recoveryEnable;
    logic [1:0] trimKey, oscClockSelect;
    logic [2:0] dominantFilterTime, tempCoeffTrim;
    logic [3:0] edgeSpacing;
    logic [4:0] fineTrim, coarseTrim;
    logic [5:0] filterTimeConstant;
    logic [6:0] recoveryClockMhz;
    logic [7:0] calHigh, calLow, payloadByteZero, payloadByteOne, q;
    int         mismatches, checked, n;
    int         domNeed [8] = '{2, 3, 4, 5, 7, 8, 9, 20};
    logic [3:0] gaps [5] = '{4'h2, 4'h5, 4'hA, 4'h3, 4'hC};
    logic [7:0] adapt [5] = '{8'h20, 8'h10, 8'h08, 8'h20, 8'h20};

    swk_config_top i_swk_config_top (.*);
    can_bus_node i_can_bus_node (.sys_clk(sys_clk), .busDominant(busDominant),
        .edgeValid(edgeValid), .edgeSpacing(edgeSpacing));

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one 16-bit frame; read bits are taken as the serial clock rises
    task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d,
                         output logic [7:0] r);
        logic [15:0] f;
        f = {d, w, a};
        r = 8'h00;
        spiCsN <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            spiDataIn <= f[k];
            cyc(4);
            spiClk <= 1'b1;
            if (k > 7) r[k-8] = spiDataOut;
            cyc(4);
            spiClk <= 1'b0;
        end
        cyc(4);
        spiCsN <= 1'b1;
        // covers the three-cycle write latency and the gap between frames
        cyc(6);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        frame(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        frame(a, 1'b0, 8'h00, r);
        chk($sformatf("reg %h", a), exp, r);
    endtask
    task automatic domTime(output int k);
        k = 0;
        i_can_bus_node.drive(1'b1);
        while (dominantDetected !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        i_can_bus_node.drive(1'b0);
        cyc(30);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // roughly 50 frames of 140 cycles plus the filter runs
    initial begin
        cyc(30000);
        mismatches++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0; softReset = 1'b0; restart = 1'b0; trimKey = 2'h0;
        calHigh = 8'hC3; calLow = 8'h3C; spiCsN = 1'b1; spiClk = 1'b0; spiDataIn = 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(1);
        chk("time constant", 8'h10, {2'h0, filterTimeConstant});
        chk("error counter", 8'h01, {7'h00, errorCounterRun});
        rd(7'h3C, 8'h04);
        rd(7'h3D, 8'h00);
        wr(7'h33, 8'hA5);
        wr(7'h32, 8'h5A);
        rd(7'h33, 8'hA5);
        rd(7'h32, 8'h5A);
        chk("payload zero", 8'hA5, payloadByteZero);
        chk("payload one", 8'h5A, payloadByteOne);
        wr(7'h34, 8'hFF);
        rd(7'h34, 8'h2F);
        chk("fd flags", 8'h01, {6'h00, errorCounterRun, fdTolerantEnable});
        wr(7'h34, 8'h20);
        chk("fd flags", 8'h02, {6'h00, errorCounterRun, fdTolerantEnable});
        i_can_bus_node.drive(1'b1);
        cyc(2);
        chk("dominant follow", 8'h01, {7'h00, dominantDetected});
        i_can_bus_node.drive(1'b0);
        cyc(3);
        for (int c = 0; c < 8; c++) begin
            wr(7'h34, {4'h0, c[2:0], 1'b1});
            chk("filter code", 8'(c), {5'h00, dominantFilterTime});
            domTime(n);
            chk("dominant delay", 8'(domNeed[c] + 1), 8'(n));
        end
        wr(7'h34, 8'h00);
        wr(7'h38, 8'h1F);
        wr(7'h39, 8'h9F);
        rd(7'h38, 8'h00);
        rd(7'h39, 8'h00);
        trimKey <= 2'h3;
        wr(7'h38, 8'h1F);
        wr(7'h39, 8'hFF);
        rd(7'h38, 8'h1F);
        rd(7'h39, 8'h9F);
        chk("fine trim", 8'h1F, {tempCoeffTrim, fineTrim});
        chk("coarse rx", 8'h9F, {receiverSelect, 2'h0, coarseTrim});
        trimKey <= 2'h0;
        rd(7'h39, 8'h1F);
        trimKey <= 2'h3;
        // clear receiver select only: coarse value is read and rewritten
        frame(7'h39, 1'b0, 8'h00, q);
        wr(7'h39, {1'b0, q[6:0]});
        chk("coarse rx", 8'h1F, {receiverSelect, 2'h0, coarseTrim});
        rd(7'h3A, 8'hC3);
        calHigh <= 8'h96;
        wr(7'h3B, 8'hFF);
        rd(7'h3B, 8'h3C);
        rd(7'h3A, 8'h96);
        for (int c = 0; c < 3; c++) begin
            wr(7'h3C, {4'h0, c[1:0], 2'h1});
            chk("time constant", 8'(8 << c), {2'h0, filterTimeConstant});
            chk("recovery enable", 8'h01, {7'h00, recoveryEnable});
        end
        wr(7'h3C, 8'hFF);
        rd(7'h3C, 8'h0D);
        foreach (gaps[i]) begin
            i_can_bus_node.gap(gaps[i]);
            cyc(3);
            chk("adaptive constant", adapt[i], {2'h0, filterTimeConstant});
        end
        for (int c = 0; c < 4; c++) begin
            wr(7'h3D, 8'(c) | 8'hFC);
            rd(7'h3D, 8'(c));
            chk("recovery clock", 8'(80 >> c), {1'b0, recoveryClockMhz});
        end
        restart <= 1'b1;
        cyc(1);
        restart <= 1'b0;
        cyc(3);
        rd(7'h3D, 8'h03);
        rd(7'h3C, 8'h0D);
        wr(7'h10, 8'hFF);
        rd(7'h10, 8'h00);
        softReset <= 1'b1;
        cyc(1);
        softReset <= 1'b0;
        cyc(3);
        rd(7'h3C, 8'h04);
        rd(7'h33, 8'h00);
        end_sim();
    end
endmodule // can_wake_frame_cdr_config_tb_top
`default_nettype wire
